// file: dst_pkg.sv
// Package for the debug sequencer and trace block.
// Assumes a 20 MHz system clock and a word-wide Avalon-MM register slave.
package dst_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] DST_IDX_STATE1  = 8'h27;
    localparam logic [9:0] DST_ADDR_STATE1 = 10'h009C;
    localparam logic [9:0] DST_ADDR_WINSEL = 10'h0100;
    localparam logic [9:0] DST_ADDR_TRCCTL = 10'h0104;
    localparam logic [9:0] DST_ADDR_STATUS = 10'h0108;
    localparam logic [9:0] DST_ADDR_TRCPTR = 10'h010C;
    localparam logic [9:0] DST_ADDR_TRCDAT = 10'h0110;
    localparam logic [9:0] DST_ADDR_ST2    = 10'h0114;
    localparam logic [9:0] DST_ADDR_ST3    = 10'h0118;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int         DST_TC_MODE_LSB = 0;
    localparam int         DST_TC_SRC_BIT  = 2;
    localparam int         DST_TC_END_BIT  = 3;
    localparam int         DST_TC_ARM_BIT  = 4;
    localparam logic [3:0] DST_CODE_RESET  = 4'h0;
    localparam logic [1:0] DST_WIN_RESET   = 2'h0;
    localparam int         DST_ADDR_W      = 18;
    localparam int         DST_TRACE_LINES = 64;

    // ************************************************************
    // Window select codes
    // ************************************************************
    localparam logic [1:0] DST_WIN_S1 = 2'h0;
    localparam logic [1:0] DST_WIN_S2 = 2'h1;
    localparam logic [1:0] DST_WIN_S3 = 2'h2;
    localparam logic [1:0] DST_WIN_MF = 2'h3;

    // Normal trace mode code
    localparam logic [1:0] DST_MODE_NORMAL = 2'h0;

    // Sequencer states, Gray along State1-State2-State3-Final
    typedef enum logic [1:0] {
        DST_ST1   = 2'b00,
        DST_ST2   = 2'b01,
        DST_ST3   = 2'b11,
        DST_FINAL = 2'b10
    } dst_state_e;

    // Change-of-flow kinds presented by the core
    typedef enum logic [3:0] {
        DST_COF_NONE     = 4'h0,
        DST_COF_CBRANCH  = 4'h1,
        DST_COF_IDX_JUMP = 4'h2,
        DST_COF_RETURN   = 4'h3,
        DST_COF_VECTOR   = 4'h4,
        DST_COF_BDM_VEC  = 4'h5,
        DST_COF_UNCOND   = 4'h6,
        DST_COF_DIRECT   = 4'h7
    } dst_cof_e;

endpackage

// file: dst_trace_mem.sv
// Trace buffer memory: one write port, one registered read port.
// Assumes the caller keeps write and read indexes in range.
`timescale 1ns/1ps
`default_nettype none
module dst_trace_mem
    import dst_pkg::*;
#(
    parameter int DEPTH = DST_TRACE_LINES,
    parameter int WIDTH = DST_ADDR_W + 1
) (
    // Clock
    input  wire logic                     clk_sys,
    // Write side
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    // Read side
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [WIDTH-1:0]         rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
        rd_data <= mem[rd_idx];
    end
endmodule
`default_nettype wire

// file: dst_state1_decode.sv
// State1 next-state decode from the selected code and match events.
// Assumes match inputs are already qualified by comparator enables.
`timescale 1ns/1ps
`default_nettype none
module dst_state1_decode
    import dst_pkg::*;
(
    // Selection
    input  wire logic [3:0] next_state_code,
    input  wire logic [2:0] match,
    // Decision
    output logic            go,
    output dst_state_e      target
);
    always_comb begin
        go     = 1'b0;
        target = DST_ST1;
        case (next_state_code)
            4'h0: if (|match) begin go = 1'b1; target = DST_FINAL; end
            4'h1: if (match[1]) begin go = 1'b1; target = DST_ST3; end
            4'h2: if (match[2]) begin go = 1'b1; target = DST_ST2; end
            4'h3: if (match[1]) begin go = 1'b1; target = DST_ST2; end
            4'h4: begin
                if (match[0]) begin go = 1'b1; target = DST_ST2; end
                else if (match[1]) begin go = 1'b1; target = DST_ST3; end
            end
            4'h5: begin
                if (match[1]) begin go = 1'b1; target = DST_ST3; end
                else if (match[0]) begin go = 1'b1; target = DST_FINAL; end
            end
            4'h6: begin
                if (match[0]) begin go = 1'b1; target = DST_ST2; end
                else if (match[2]) begin go = 1'b1; target = DST_ST3; end
            end
            4'h7: if (match[0] | match[1]) begin go = 1'b1; target = DST_ST2; end
            4'h9: if (match[0]) begin go = 1'b1; target = DST_ST3; end
            default: begin go = 1'b0; target = DST_ST1; end
        endcase
    end
endmodule
`default_nettype wire

// file: dst_debug_trace.sv
// Debug sequencer and change-of-flow trace buffer, Avalon-MM slave.
// Assumes core events are synchronous to clk_sys, one per cycle.
// Overview of operation
// - Window select picks state2, state3, match flags
// - State1 register readable/writable only at window 00
// - Four-bit code steers State1 on matches
// - Codes 0000 to 0011 map matches
// - Codes 0100 to 1001 map matches, 1000 reserved
// - Begin alignment stores after Final, 64 lines
// - Begin alignment stores triggering change of flow
// - Tagged begin trace; breakpoint at session end
// - End alignment stores until Final, then disarms
// - End alignment drops triggering change of flow
// - End alignment wraps over oldest lines
// - Mode field plus source enable bit
// - Normal mode stores taken conditional branch sources
// - Normal mode stores indexed, return, vector destinations
// - Unconditional and direct transfers never stored
// - Entry holds 18-bit address and source flag
// - Destination stored at completion despite interrupt
`timescale 1ns/1ps
`default_nettype none
module dst_debug_trace
    import dst_pkg::*;
#(
    parameter int DEPTH = DST_TRACE_LINES
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // Avalon-MM slave
    input  wire logic [9:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Core event stream
    input  wire logic [2:0]            match_in,
    input  wire logic                  tag_hit,
    input  wire logic                  cof_valid,
    input  wire logic [3:0]            cof_kind,
    input  wire logic [DST_ADDR_W-1:0] cof_addr,
    // Status
    output logic                       armed_out,
    output logic                       breakpoint_out,
    output logic [1:0]                 seq_state_out
);
    localparam int IW = $clog2(DEPTH);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [3:0]            state1_next_state_reg;
    logic [3:0]            state2_next_state_reg;
    logic [3:0]            state3_next_state_reg;
    logic [1:0]            register_window_select;
    logic [4:0]            trace_control_reg;
    logic [2:0]            match_flag_reg;
    dst_state_e            state_reg, state_next;
    logic                  armed_reg;
    logic [IW-1:0]         wr_idx_reg;
    logic [IW:0]           stored_reg;
    logic [IW-1:0]         rd_idx_reg;
    logic                  ack_reg;
    logic                  bkpt_reg;

    // ************************************************************
    // Decode
    // ************************************************************
    wire logic [1:0] trace_mode_select   = trace_control_reg[DST_TC_MODE_LSB +: 2];
    wire logic       trace_source_enable = trace_control_reg[DST_TC_SRC_BIT];
    wire logic       end_align           = trace_control_reg[DST_TC_END_BIT];
    wire logic       acc                 = (avs_read | avs_write) & ~ack_reg;
    // Writes commit only at the edge that ends the wait
    wire logic       wr                  = avs_write & ack_reg;
    wire logic       win1                = register_window_select == DST_WIN_S1;
    // Writes locked while armed so the sequence cannot change mid-run
    wire logic       wr_s1  = wr & (avs_address == DST_ADDR_STATE1) & win1 & ~armed_reg;
    wire logic       wr_arm = wr & (avs_address == DST_ADDR_TRCCTL);
    wire logic       s1_go;
    dst_state_e      s1_target;

    dst_state1_decode u_dec (
        .next_state_code (state1_next_state_reg),
        .match           (match_in),
        .go              (s1_go),
        .target          (s1_target)
    );

    // Change-of-flow qualification
    wire logic is_src = cof_kind == DST_COF_CBRANCH;
    wire logic is_dst = (cof_kind == DST_COF_IDX_JUMP) | (cof_kind == DST_COF_RETURN)
                      | (cof_kind == DST_COF_VECTOR);
    // Destination entries land at completion even with a pending interrupt
    wire logic cof_ok = cof_valid & (is_src | is_dst) & trace_source_enable
                      & (trace_mode_select == DST_MODE_NORMAL);
    wire logic enter_final = armed_reg & (state_reg != DST_FINAL) & (state_next == DST_FINAL);
    wire logic in_final    = state_reg == DST_FINAL;
    // Begin: store from trigger cycle on; end: store before trigger only
    wire logic store = armed_reg & cof_ok &
                       (end_align ? ~in_final & ~enter_final
                                  : (in_final | enter_final));
    wire logic full_begin = ~end_align & in_final & (stored_reg == (IW+1)'(DEPTH));

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DST_ST1: if (s1_go) state_next = s1_target;
            DST_ST2: if (|(match_in & state2_next_state_reg[2:0])) state_next = DST_FINAL;
            DST_ST3: if (|(match_in & state3_next_state_reg[2:0])) state_next = DST_FINAL;
            default: state_next = state_reg;
        endcase
        // Tagged begin trace triggers on the tagged instruction
        if (tag_hit & ~end_align & (state_reg != DST_FINAL)) state_next = DST_FINAL;
        if (~armed_reg) state_next = DST_ST1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= DST_ST1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // Arm control and trace pointer
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            armed_reg  <= 1'b0;
            bkpt_reg   <= 1'b0;
            wr_idx_reg <= '0;
            stored_reg <= '0;
        end else begin
            bkpt_reg <= 1'b0;
            if (wr_arm & avs_writedata[DST_TC_ARM_BIT]) begin
                armed_reg  <= 1'b1;
                wr_idx_reg <= '0;
                stored_reg <= '0;
            end else if (armed_reg & end_align & enter_final) begin
                armed_reg <= 1'b0;
                bkpt_reg  <= 1'b1;
            end else if (full_begin) begin
                armed_reg <= 1'b0;
                bkpt_reg  <= 1'b1;
            end else if (store) begin
                wr_idx_reg <= wr_idx_reg + 1'b1;
                if (stored_reg != (IW+1)'(DEPTH)) stored_reg <= stored_reg + 1'b1;
            end
        end
    end

    logic [DST_ADDR_W:0] trace_rd;

    dst_trace_mem #(.DEPTH(DEPTH), .WIDTH(DST_ADDR_W + 1)) u_mem (
        .clk_sys (clk_sys),
        .wr_en   (store & ~full_begin),
        .wr_idx  (wr_idx_reg),
        .wr_data ({is_src, cof_addr}),
        .rd_idx  (rd_idx_reg),
        .rd_data (trace_rd)
    );

    // ************************************************************
    // Register file
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state1_next_state_reg  <= DST_CODE_RESET;
            state2_next_state_reg  <= DST_CODE_RESET;
            state3_next_state_reg  <= DST_CODE_RESET;
            register_window_select <= DST_WIN_RESET;
            trace_control_reg      <= '0;
            rd_idx_reg             <= '0;
        end else begin
            if (wr_s1) state1_next_state_reg <= avs_writedata[3:0];
            if (wr & avs_address == DST_ADDR_ST2 & ~armed_reg) state2_next_state_reg <= avs_writedata[3:0];
            if (wr & avs_address == DST_ADDR_ST3 & ~armed_reg) state3_next_state_reg <= avs_writedata[3:0];
            if (wr & avs_address == DST_ADDR_WINSEL) register_window_select <= avs_writedata[1:0];
            if (wr_arm) trace_control_reg <= {1'b0, avs_writedata[3:0]};
            if (wr & avs_address == DST_ADDR_TRCPTR) rd_idx_reg <= avs_writedata[IW-1:0];
        end
    end

    // Match flags: set wins over clear by arm
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            match_flag_reg <= '0;
        end else begin
            match_flag_reg <= (wr_arm ? 3'h0 : match_flag_reg) | (armed_reg ? match_in : 3'h0);
        end
    end

    // Shared address shows the register picked by the window
    wire logic [3:0] win_data = (register_window_select == DST_WIN_S2) ? state2_next_state_reg
                              : (register_window_select == DST_WIN_S3) ? state3_next_state_reg
                              : (register_window_select == DST_WIN_MF) ? {1'b0, match_flag_reg}
                              : state1_next_state_reg;
    wire logic [31:0] rd_mux =
        (avs_address == DST_ADDR_STATE1) ? {28'h0000_000, win_data} :
        (avs_address == DST_ADDR_WINSEL) ? {30'h0000_0000, register_window_select} :
        (avs_address == DST_ADDR_TRCCTL) ? {27'h000_0000, armed_reg, trace_control_reg[3:0]} :
        (avs_address == DST_ADDR_STATUS) ? 32'({stored_reg, state_reg}) :
        (avs_address == DST_ADDR_TRCPTR) ? 32'(wr_idx_reg) :
        (avs_address == DST_ADDR_TRCDAT) ? {13'h0000, trace_rd} :
        32'h0000_0000;

    // One wait cycle so the trace memory read register settles
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ack_reg         <= 1'b0;
            avs_readdata    <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
        end else begin
            ack_reg         <= acc;
            avs_readdata    <= acc ? rd_mux : avs_readdata;
            avs_waitrequest <= ~acc;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            armed_out      <= 1'b0;
            breakpoint_out <= 1'b0;
            seq_state_out  <= 2'b00;
        end else begin
            armed_out      <= armed_reg;
            breakpoint_out <= bkpt_reg;
            seq_state_out  <= state_reg;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_WIN_S2: assert property ((register_window_select == DST_WIN_S2) |-> win_data == state2_next_state_reg)
        else $error("window 01 wrong");
    AST_S1_LOCK: assert property ((armed_reg & wr) |=> $stable(state1_next_state_reg))
        else $error("state1 code changed while armed");
    AST_RSVD: assert property ((state_reg == DST_ST1 & armed_reg & ~tag_hit & state1_next_state_reg == 4'h8) |=> state_reg == DST_ST1)
        else $error("reserved code moved state");
    AST_C0: assert property ((state_reg == DST_ST1 & armed_reg & ~wr_arm & state1_next_state_reg == 4'h0 & |match_in) |=> state_reg == DST_FINAL)
        else $error("code 0000 no final");
    AST_C9: assert property ((state_reg == DST_ST1 & armed_reg & ~tag_hit & state1_next_state_reg == 4'h9 & match_in == 3'b001) |=> state_reg == DST_ST3)
        else $error("code 1001 no state3");
    AST_NOSTORE_PRE: assert property ((~end_align & state_reg != DST_FINAL & ~enter_final) |-> ~store)
        else $error("begin stored early");
    AST_END_DISARM: assert property ((armed_reg & end_align & enter_final & ~wr_arm) |=> ~armed_reg ##1 ~armed_reg)
        else $error("end align not disarmed");
    AST_UNCOND: assert property ((cof_kind == DST_COF_UNCOND | cof_kind == DST_COF_DIRECT | cof_kind == DST_COF_BDM_VEC) |-> ~store)
        else $error("non cof stored");
    AST_WRAP: assert property ((store & ~full_begin & ~wr_arm & wr_idx_reg == IW'(DEPTH-1)) |=> wr_idx_reg == '0)
        else $error("no wrap");
    COV_FINAL: cover property (enter_final);
    COV_FULL: cover property (full_begin);
    COV_WRAP: cover property (store & end_align & wr_idx_reg == IW'(DEPTH-1));
endmodule
`default_nettype wire

// file: dst_core_model.sv
// Core-side model: comparator matches, tag hits and change-of-flow pulses.
// Assumes one clk_sys domain; the bench calls emit, one event per call.
`timescale 1ns/1ps
`default_nettype none
module dst_core_model
    import dst_pkg::*;
(
    // Clock and comparator enables
    input  wire logic                  clk_sys,
    input  wire logic [2:0]            comp_en,
    // Event stream
    output logic      [2:0]            match_in,
    output logic                       tag_hit,
    output logic                       cof_valid,
    output logic      [3:0]            cof_kind,
    output logic      [DST_ADDR_W-1:0] cof_addr
);
    initial begin
        match_in  = 3'h0;
        tag_hit   = 1'b0;
        cof_valid = 1'b0;
        cof_kind  = DST_COF_NONE;
        cof_addr  = '0;
    end

    // ************************************************
    // One-cycle event, then idle
    // ************************************************
    task automatic emit(input logic [3:0] k, input logic [DST_ADDR_W-1:0] a, input logic [2:0] m, input logic t);
        @(posedge clk_sys);
        match_in  <= m & comp_en;
        tag_hit   <= t;
        cof_valid <= (k != DST_COF_NONE);
        cof_kind  <= k;
        cof_addr  <= a;
        @(posedge clk_sys);
        match_in  <= 3'h0;
        tag_hit   <= 1'b0;
        cof_valid <= 1'b0;
        cof_kind  <= DST_COF_NONE;
        // Address is not held after the pulse
        cof_addr  <= ~a;
    endtask
endmodule
`default_nettype wire

// file: dst_debug_trace_tb.sv
// Self-checking bench for the debug sequencer and trace block.
// Assumes Avalon-MM answer after one cycle and a shortened trace buffer.
`timescale 1ns/1ps
`default_nettype none
module dst_debug_trace_tb
    import dst_pkg::*;
;
    localparam int DEPTH = 8;
    logic        clk_sys;
    logic        rst_n;
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  match_in;
    logic [2:0]  comp_en;
    logic        tag_hit;
    logic        cof_valid;
    logic [3:0]  cof_kind;
    logic [17:0] cof_addr;
    logic        armed_out;
    logic        breakpoint_out;
    logic [1:0]  seq_state_out;
    logic [31:0] rd;
    int          err_total;
    int          tests_run;
    int          cycles;
    int          bp_count;

    dst_debug_trace #(.DEPTH(DEPTH)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .match_in(match_in), .tag_hit(tag_hit), .cof_valid(cof_valid),
        .cof_kind(cof_kind), .cof_addr(cof_addr), .armed_out(armed_out), .breakpoint_out(breakpoint_out),
        .seq_state_out(seq_state_out));
    dst_core_model i_core (.clk_sys(clk_sys), .comp_en(comp_en), .match_in(match_in), .tag_hit(tag_hit),
        .cof_valid(cof_valid), .cof_kind(cof_kind), .cof_addr(cof_addr));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Hang guard, well above the expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end

    // Pulses counted mid-cycle, clear of the launching edge
    always @(negedge clk_sys) begin
        if (breakpoint_out === 1'b1) bp_count++;
    end

    // ************************************************
    // Bus, compare and closing tasks
    // ************************************************
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) chk(32'h0000_0001, 32'h0000_0000, "bus timeout");
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp, what);
    endtask

    task automatic line_chk(input int l, input logic [18:0] exp);
        bus(1'b1, DST_ADDR_TRCPTR, 32'(l));
        bus(1'b0, DST_ADDR_TRCDAT, 32'h0000_0000);
        chk({13'h0000, rd[18:0]}, {13'h0000, exp}, "trace line");
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        bp_count = 0;
    endtask

    function automatic dst_state_e nxt(input logic [3:0] c, input int m);
        case (c)
            4'h0: return DST_FINAL;
            4'h1: return (m == 1) ? DST_ST3 : DST_ST1;
            4'h2: return (m == 2) ? DST_ST2 : DST_ST1;
            4'h3: return (m == 1) ? DST_ST2 : DST_ST1;
            4'h4: return (m == 0) ? DST_ST2 : (m == 1) ? DST_ST3 : DST_ST1;
            4'h5: return (m == 1) ? DST_ST3 : (m == 0) ? DST_FINAL : DST_ST1;
            4'h6: return (m == 0) ? DST_ST2 : (m == 2) ? DST_ST3 : DST_ST1;
            4'h7: return (m < 2) ? DST_ST2 : DST_ST1;
            4'h9: return (m == 0) ? DST_ST3 : DST_ST1;
            default: return DST_ST1;
        endcase
    endfunction

    // Entry e: 0 source, 1..3 destinations, then sources from 0x200
    function automatic logic [18:0] line_exp(input int e);
        if (e == 0) return {1'b1, 18'h0_0101};
        if (e < 4) return {1'b0, 18'h0_0100 + 18'(e + 1)};
        return {1'b1, 18'h0_0200 + 18'(e - 4)};
    endfunction

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        rst_n = 1'b0;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        comp_en = 3'h7;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdchk(DST_ADDR_STATUS, 32'h0000_0000, "status reset");
        rdchk(10'h3FC, 32'h0000_0000, "unmapped read");
        bus(1'b1, DST_ADDR_STATE1, 32'h0000_0005);
        rdchk(DST_ADDR_STATE1, 32'h0000_0005, "state1 write");
        bus(1'b1, DST_ADDR_ST2, 32'h0000_0003);
        bus(1'b1, DST_ADDR_ST3, 32'h0000_0006);
        bus(1'b1, DST_ADDR_WINSEL, 32'h0000_0001);
        rdchk(DST_ADDR_STATE1, 32'h0000_0003, "window state2");
        bus(1'b1, DST_ADDR_STATE1, 32'h0000_0009);
        bus(1'b1, DST_ADDR_WINSEL, 32'h0000_0002);
        rdchk(DST_ADDR_STATE1, 32'h0000_0006, "window state3");
        bus(1'b1, DST_ADDR_WINSEL, 32'h0000_0000);
        rdchk(DST_ADDR_STATE1, 32'h0000_0005, "hidden write");
        bus(1'b1, DST_ADDR_TRCCTL, 32'h0000_0014);
        bus(1'b1, DST_ADDR_STATE1, 32'h0000_0007);
        rdchk(DST_ADDR_STATE1, 32'h0000_0005, "armed write");
        i_core.emit(DST_COF_NONE, 18'h0_0000, 3'h2, 1'b0);
        bus(1'b1, DST_ADDR_WINSEL, 32'h0000_0003);
        rdchk(DST_ADDR_STATE1, 32'h0000_0002, "window flags");
        for (int c = 0; c < 16; c++) begin
            for (int m = 0; m < 3; m++) begin
                do_reset();
                bus(1'b1, DST_ADDR_STATE1, 32'(c));
                bus(1'b1, DST_ADDR_TRCCTL, 32'h0000_0014);
                i_core.emit(DST_COF_NONE, 18'h0_0000, 3'(1 << m), 1'b0);
                bus(1'b0, DST_ADDR_STATUS, 32'h0000_0000);
                chk(seq_state_out, nxt(4'(c), m), "next state");
            end
        end
        // End alignment: every kind once, wrap, then trigger on a branch
        do_reset();
        bus(1'b1, DST_ADDR_TRCCTL, 32'h0000_001C);
        for (int k = 1; k < 8; k++) i_core.emit(4'(k), 18'h0_0100 + 18'(k), 3'h0, 1'b0);
        for (int i = 0; i < 6; i++) i_core.emit(DST_COF_CBRANCH, 18'h0_0200 + 18'(i), 3'h0, 1'b0);
        i_core.emit(DST_COF_CBRANCH, 18'h3_FFFF, 3'h1, 1'b0);
        i_core.emit(DST_COF_CBRANCH, 18'h2_AAAA, 3'h0, 1'b0);
        bus(1'b0, DST_ADDR_TRCPTR, 32'h0000_0000);
        chk(rd[2:0], 3'h2, "write index");
        chk(armed_out, 1'b0, "disarm at final");
        chk(bp_count, 1, "end breakpoint");
        for (int l = 0; l < DEPTH; l++) line_chk(l, line_exp((l < 2) ? l + 8 : l));
        // Begin alignment, triggered by a match and then by a tag
        for (int t = 0; t < 2; t++) begin
            do_reset();
            bus(1'b1, DST_ADDR_TRCCTL, 32'h0000_0014);
            i_core.emit(DST_COF_CBRANCH, 18'h0_0111, 3'h0, 1'b0);
            i_core.emit(DST_COF_IDX_JUMP, 18'h0_3000, 3'(1 - t), 1'(t));
            chk(bp_count, 0, "early breakpoint");
            chk(armed_out, 1'b1, "armed after trigger");
            for (int i = 1; i < DEPTH; i++) i_core.emit(DST_COF_RETURN, 18'h0_3000 + 18'(i), 3'h0, 1'b0);
            bus(1'b0, DST_ADDR_STATUS, 32'h0000_0000);
            chk(armed_out, 1'b0, "disarm after fill");
            chk(bp_count, 1, "session breakpoint");
            line_chk(0, {1'b0, 18'h0_3000});
        end
        // Mode 01 and a cleared source bit record nothing
        for (int v = 0; v < 2; v++) begin
            do_reset();
            bus(1'b1, DST_ADDR_TRCCTL, (v == 0) ? 32'h0000_001D : 32'h0000_0018);
            i_core.emit(DST_COF_CBRANCH, 18'h0_0777, 3'h0, 1'b0);
            bus(1'b0, DST_ADDR_TRCPTR, 32'h0000_0000);
            chk(rd[2:0], 3'h0, "no recording");
        end
        close_out();
    end
endmodule
`default_nettype wire
